// File: core/ipm_cfg.svh
// constants for the idle / power-down mode controller
// assumes inclusion by the package and by the design modules
`ifndef IPM_CFG_SVH
`define IPM_CFG_SVH
`define IPM_WB_ADDR_W 4
`define IPM_REG_CTRL 4'h0
`define IPM_REG_STAT 4'h4
`define IPM_REG_WDOG 4'h8
`define IPM_CTRL_POWERDOWN_CONFIG_SELECT 0
`define IPM_CTRL_RTCEN 1
`define IPM_CTRL_LPDIS 2
`define IPM_CTRL_RST 3'h0
`define IPM_WDOG_RST 16'hffff
`define IPM_IDLE_OP 32'h87787887
`define IPM_POWERDOWN_INSTRUCTION_OP 32'h97686897
`define IPM_PRIO_W 4
`define IPM_PRIO_ZERO 4'h0
`define IPM_SRC_N 4
`define IPM_LP_DET_CNT 3'h4
`endif

// File: core/ipm_ctrl.sv
// idle and power-down mode controller with a classic wishbone register slave
// assumes cpu decode, interrupt controller and bus controller on the same clock
//
// Overview of operation
// - idle halts cpu only, peripherals run
// - idle after protected 32-bit opcode, prior done
// - external bus cycles finish before entry
// - refuse entry if enabled ready missed
// - any reset or interrupt ends idle
// - enabled source wakes regardless priority, enable
// - serviceable cpu request enters routine, resumes
// - unserviceable cpu request resumes, no re-idle
// - serviceable transfer request keeps cpu idle
// - unserviceable transfer request leaves idle
// - nmi falling edge ends idle, trap taken
// - one prioritisation round after wake
// - priority zero wakes, vector not taken
// - watchdog counts in idle, overflow resets
// - power-down stops cpu and peripherals
// - power-down exits: reset; in config 1 also fast irq, rtc, serial
// - low-power osc running: main osc stops
// - detect low-power osc, adopt, keep unless disabled
// - only main osc: keep it in power-down while rtc enabled
// - config 0: enter only with nmi low
// - config 1: enter only with fast pins inactive
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ipm_cfg.svh"
module ipm_ctrl
    import ipm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`IPM_WB_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // cpu side
    input wire logic op_valid_i,
    input wire logic [31:0] op_word_i,
    input wire logic prev_done_i,
    input wire logic global_irq_enable_i,
    input wire logic [`IPM_PRIO_W-1:0] cpu_prio_i,
    input wire logic return_from_service_i,
    // interrupt controller side
    input wire ipm_req_t wake_req_i,
    input wire logic pec_done_i,
    // bus controller side
    input wire logic bus_busy_i,
    input wire logic ready_en_i,
    input wire logic ready_seen_i,
    // pins
    input wire logic nmi_n_i,
    input wire logic [`IPM_SRC_N-1:0] fast_external_irq_pins_i,
    input wire logic [`IPM_SRC_N-1:0] fast_irq_en_i,
    input wire logic [`IPM_SRC_N-1:0] fast_irq_active_high_i,
    input wire logic lp_osc_clk_i,
    // wake sources for power-down
    input wire logic rtc_irq_i,
    input wire logic serial_irq_i,
    // mode and control outputs
    output ipm_mode_t mode_o,
    output logic cpu_halt_o,
    output logic periph_stop_o,
    output logic main_osc_stop_o,
    output logic rtc_ref_lp_o,
    output logic isr_enter_o,
    output logic nmi_trap_o,
    output logic prio_round_o,
    output logic resume_next_o,
    output logic wdog_reset_o
);
    typedef struct packed {
        ipm_mode_t mode;
        logic [2:0] ctrl;
        logic [15:0] wdog_reload;
        logic [15:0] wdog_cnt;
        logic lp_sel;
        logic [2:0] lp_cnt;
        logic lp_prev;
        logic nmi_prev;
        logic [31:0] dat;
        logic ack;
        logic halt;
        logic pstop;
        logic osc_stop;
        logic isr;
        logic trap;
        logic round;
        logic resume;
        logic wrst;
    } ipm_state_t;

    ipm_state_t s;
    ipm_state_t next_s;
    logic nmi_n_s;
    logic nmi_s;
    logic wb_wr;
    logic lp_s;
    logic [`IPM_SRC_N-1:0] fast_s;
    logic [`IPM_SRC_N-1:0] fast_act;
    logic wb_go;
    logic entry_ok;
    logic idle_op;
    logic powerdown_instruction_op;
    logic serviceable;
    logic pd_wake;

    // the nmi, fast interrupt and low-power oscillator pins cross in through two flops each before any logic sees them
    ipm_sync #(.W(`IPM_SRC_N + 2)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({fast_external_irq_pins_i, ~nmi_n_i, lp_osc_clk_i}),
        .q_o({fast_s, nmi_s, lp_s})
    );
    // nmi rests high, so it crosses inverted: the cleared synchroniser reads as idle
    assign nmi_n_s = ~nmi_s;

    // true when the wishbone word matches a register offset
    function automatic logic hit(input logic [`IPM_WB_ADDR_W-1:0] a,
                                 input logic [`IPM_WB_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // per-pin active level of the fast external interrupts
    genvar g;
    generate
        for (g = 0; g < `IPM_SRC_N; g++) begin : g_fast
            assign fast_act[g] = fast_irq_en_i[g] &
                                 (fast_s[g] == fast_irq_active_high_i[g]);
        end
    endgenerate

    assign wb_go = wb_cyc_i & wb_stb_i & ~s.ack;
    // the master still holds the request on the edge where it sees ack
    assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & s.ack;
    assign idle_op = op_valid_i & (op_word_i == `IPM_IDLE_OP) & prev_done_i;
    assign powerdown_instruction_op = op_valid_i & (op_word_i == `IPM_POWERDOWN_INSTRUCTION_OP) & prev_done_i;
    // pending bus cycles and a missed ready both hold the cpu in run
    assign entry_ok = ~bus_busy_i & ~(ready_en_i & ~ready_seen_i);
    // priority zero never beats the cpu, so no vector is fetched
    assign serviceable = global_irq_enable_i & (wake_req_i.prio > cpu_prio_i) &
                         (wake_req_i.prio != `IPM_PRIO_ZERO);
    assign pd_wake = (|fast_act) | (s.ctrl[`IPM_CTRL_RTCEN] & rtc_irq_i) |
                     serial_irq_i;

    // whole next state in one place
    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.isr = 1'b0;
        next_s.trap = 1'b0;
        next_s.round = 1'b0;
        next_s.resume = 1'b0;
        next_s.wrst = 1'b0;
        next_s.nmi_prev = nmi_n_s;
        next_s.lp_prev = lp_s;
        // register slave answers one cycle after the strobe
        if (wb_go) begin
            next_s.ack = 1'b1;
            next_s.dat = 32'h0;
            if (hit(wb_adr_i, `IPM_REG_CTRL)) begin
                next_s.dat = {29'h0, s.ctrl};
            end else if (hit(wb_adr_i, `IPM_REG_STAT)) begin
                next_s.dat = {27'h0, s.lp_sel, s.osc_stop, s.mode == IPM_PDOWN,
                              s.mode == IPM_IDLE, s.mode == IPM_RUN};
            end else if (hit(wb_adr_i, `IPM_REG_WDOG)) begin
                next_s.dat = {s.wdog_cnt, s.wdog_reload};
            end
        end
        // watchdog runs in run and idle, frozen in power-down
        if (s.mode != IPM_PDOWN) begin
            if (s.wdog_cnt == s.wdog_reload) begin
                next_s.wrst = 1'b1;
                next_s.wdog_cnt = '0;
                next_s.mode = IPM_RUN;
            end else begin
                next_s.wdog_cnt = s.wdog_cnt + 16'h1;
            end
        end
        // writes land on the ack edge; placed after the watchdog so that a
        // write clears the count instead of losing to the increment
        if (wb_wr) begin
            if (hit(wb_adr_i, `IPM_REG_CTRL) && wb_sel_i[0]) begin
                next_s.ctrl = wb_dat_i[2:0];
            end
            if (hit(wb_adr_i, `IPM_REG_WDOG)) begin
                if (wb_sel_i[0]) begin
                    next_s.wdog_reload[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    next_s.wdog_reload[15:8] = wb_dat_i[15:8];
                end
                next_s.wdog_cnt = '0;
            end
        end
        // low-power oscillator detector: count edges, latch once found
        if (lp_s != s.lp_prev && s.lp_cnt != `IPM_LP_DET_CNT) begin
            next_s.lp_cnt = s.lp_cnt + 3'h1;
        end
        if (s.lp_cnt == `IPM_LP_DET_CNT && !s.ctrl[`IPM_CTRL_LPDIS]) begin
            next_s.lp_sel = 1'b1;
        end
        if (s.ctrl[`IPM_CTRL_LPDIS]) begin
            next_s.lp_sel = 1'b0;
            next_s.lp_cnt = '0;
        end
        // mode sequencer
        case (s.mode)
            IPM_RUN: begin
                if (idle_op && entry_ok) begin
                    next_s.mode = IPM_IDLE;
                end else if (powerdown_instruction_op && entry_ok) begin
                    if (!s.ctrl[`IPM_CTRL_POWERDOWN_CONFIG_SELECT] && !nmi_n_s) begin
                        next_s.mode = IPM_PDOWN;
                    end else if (s.ctrl[`IPM_CTRL_POWERDOWN_CONFIG_SELECT] && !(|fast_act)) begin
                        next_s.mode = IPM_PDOWN;
                    end
                end
            end
            IPM_IDLE: begin
                if (s.nmi_prev && !nmi_n_s) begin
                    next_s.mode = IPM_RUN;
                    next_s.trap = 1'b1;
                    next_s.round = 1'b1;
                end else if (wake_req_i.valid) begin
                    next_s.round = 1'b1;
                    if (wake_req_i.is_pec && serviceable) begin
                        next_s.mode = IPM_IDLE;
                    end else begin
                        next_s.mode = IPM_RUN;
                        next_s.isr = serviceable;
                        next_s.resume = ~serviceable;
                    end
                end
            end
            IPM_PDOWN: begin
                if (s.ctrl[`IPM_CTRL_POWERDOWN_CONFIG_SELECT] && pd_wake) begin
                    next_s.mode = IPM_RUN;
                    next_s.round = 1'b1;
                end
            end
            default: begin
                next_s.mode = IPM_RUN;
            end
        endcase
        // the service routine returns to the word after the idle opcode
        if (return_from_service_i && s.mode == IPM_RUN) begin
            next_s.resume = 1'b1;
        end
        next_s.halt = (next_s.mode != IPM_RUN);
        next_s.pstop = (next_s.mode == IPM_PDOWN);
        // main clock survives power-down only while the enabled rtc runs from it and not from the low-power oscillator
        next_s.osc_stop = (next_s.mode == IPM_PDOWN) &
                          (next_s.lp_sel | ~s.ctrl[`IPM_CTRL_RTCEN]);
    end

    // one register stage for all state; reset ends every mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.mode <= IPM_RUN;
            s.ctrl <= `IPM_CTRL_RST;
            s.wdog_reload <= `IPM_WDOG_RST;
            s.nmi_prev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign mode_o = s.mode;
    assign cpu_halt_o = s.halt;
    assign periph_stop_o = s.pstop;
    assign main_osc_stop_o = s.osc_stop;
    assign rtc_ref_lp_o = s.lp_sel;
    assign isr_enter_o = s.isr;
    assign nmi_trap_o = s.trap;
    assign prio_round_o = s.round;
    assign resume_next_o = s.resume;
    assign wdog_reset_o = s.wrst;
    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;

    // a serviceable transfer never drops the cpu out of idle
    AST_PEC_STAYS: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_IDLE && wake_req_i.valid && wake_req_i.is_pec && serviceable &&
         !(s.nmi_prev && !nmi_n_s) && s.wdog_cnt != s.wdog_reload)
        |=> mode_o == IPM_IDLE)
        else $error("transfer request left idle");
    AST_UNSERV_RESUME: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_IDLE && wake_req_i.valid && !serviceable &&
         !(s.nmi_prev && !nmi_n_s) && s.wdog_cnt != s.wdog_reload)
        |=> (mode_o == IPM_RUN && resume_next_o && !isr_enter_o))
        else $error("unserviced request did not resume");
    AST_NMI_TRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_IDLE && $fell(nmi_n_s) && s.wdog_cnt != s.wdog_reload)
        |=> (nmi_trap_o && prio_round_o && mode_o == IPM_RUN))
        else $error("nmi did not end idle");
    AST_NO_ENTRY_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_RUN && bus_busy_i) |=> mode_o == IPM_RUN)
        else $error("mode entered with bus busy");
    AST_READY_MISS: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_RUN && ready_en_i && !ready_seen_i) |=> mode_o == IPM_RUN)
        else $error("mode entered after missed ready");
    AST_PD_NMI_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_RUN && !s.ctrl[`IPM_CTRL_POWERDOWN_CONFIG_SELECT] && nmi_n_s) |=> mode_o != IPM_PDOWN)
        else $error("protected power-down with nmi high");
    AST_PD_STUCK: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_PDOWN && !s.ctrl[`IPM_CTRL_POWERDOWN_CONFIG_SELECT]) |=> mode_o == IPM_PDOWN)
        else $error("protected power-down left without reset");
    AST_PD_FAST: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_RUN && s.ctrl[`IPM_CTRL_POWERDOWN_CONFIG_SELECT] && (|fast_act)) |=> mode_o != IPM_PDOWN)
        else $error("power-down entered with fast pin active");
    AST_HALT_TIE: assert property (@(posedge clk_i) disable iff (rst_i)
        (cpu_halt_o == (mode_o != IPM_RUN)) && (periph_stop_o == (mode_o == IPM_PDOWN)))
        else $error("halt outputs disagree with mode");
    AST_OSC: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_o == IPM_PDOWN && !rtc_ref_lp_o && s.ctrl[`IPM_CTRL_RTCEN]) |-> !main_osc_stop_o)
        else $error("main oscillator stopped while feeding rtc");
    AST_WDOG: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_IDLE && s.wdog_cnt == s.wdog_reload) |=> (wdog_reset_o && mode_o == IPM_RUN))
        else $error("watchdog overflow missed in idle");
    // reset leaves every mode and clears the halt lines
    AST_RST_RUN: assert property (@(posedge clk_i)
        rst_i |=> (mode_o == IPM_RUN && !cpu_halt_o && !periph_stop_o))
        else $error("reset did not return to run");
    // a serviceable cpu request leaves idle into its routine
    AST_ISR_SERV: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_IDLE && wake_req_i.valid && !wake_req_i.is_pec && serviceable &&
         !(s.nmi_prev && !nmi_n_s) && s.wdog_cnt != s.wdog_reload)
        |=> (mode_o == IPM_RUN && isr_enter_o && !resume_next_o))
        else $error("serviceable request did not enter its routine");
    // a level zero request ends idle but never reaches its vector
    AST_PRIO_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == IPM_IDLE && wake_req_i.valid && wake_req_i.prio == `IPM_PRIO_ZERO &&
         !(s.nmi_prev && !nmi_n_s) && s.wdog_cnt != s.wdog_reload)
        |=> (mode_o == IPM_RUN && !isr_enter_o))
        else $error("level zero request took its vector");
    // ack is a single-cycle pulse so one strobe is answered once
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for two cycles");
endmodule // ipm_ctrl
`default_nettype wire

// File: core/ipm_pkg.sv
// types of the idle / power-down mode controller
// assumes ipm_cfg.svh is on the include path
`include "ipm_cfg.svh"
package ipm_pkg;
    typedef enum logic [1:0] {
        IPM_RUN,
        IPM_IDLE,
        IPM_PDOWN
    } ipm_mode_t;
    // one pending wake request as the interrupt controller reports it
    typedef struct packed {
        logic valid;
        logic is_pec;
        logic [`IPM_PRIO_W-1:0] prio;
    } ipm_req_t;
endpackage

// File: core/ipm_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
// assumes one system clock and a synchronous reset
`timescale 1ns/1ns
`default_nettype none
module ipm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin side and synchronised side
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    // first stage is read only by the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // ipm_sync
`default_nettype wire

// File: dv/ipm_far_model.sv
// far side of the mode controller: cpu decode, interrupt and bus controller
// assumes the controller's clock and registered pulse outputs
`timescale 1ns/1ns
`default_nettype none
module ipm_far_model
    import ipm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // controller feedback
    input wire logic prio_round_i,
    input wire logic wdog_reset_i,
    // requests towards the controller
    output logic op_valid_o,
    output logic [31:0] op_word_o,
    output logic prev_done_o,
    output ipm_req_t wake_req_o,
    output logic bus_busy_o
);
    // quiet start: no opcode, nothing pending
    initial begin
        op_valid_o = 1'b0;
        op_word_o = 32'h0;
        prev_done_o = 1'b1;
        wake_req_o = '0;
        bus_busy_o = 1'b0;
    end
    // one-cycle opcode; the released word is inverted so a stale copy never matches
    task automatic issue(input logic [31:0] w);
        @(posedge clk_i);
        op_valid_o <= 1'b1;
        op_word_o <= w;
        @(posedge clk_i);
        op_valid_o <= 1'b0;
        op_word_o <= ~w;
    endtask
    // pending request stays a level until the controller prioritises it
    task automatic raise(input logic peripheral_event_transfer, input logic [3:0] p);
        @(posedge clk_i);
        wake_req_o <= '{valid: 1'b1, is_pec: peripheral_event_transfer, prio: p};
    endtask
    task automatic set_bus(input logic busy, input logic done);
        bus_busy_o <= busy;
        prev_done_o <= done;
    endtask
    // the round consumes the request, like an acknowledged interrupt
    always @(posedge clk_i) begin
        if (rst_i || prio_round_i || wdog_reset_i) begin
            wake_req_o.valid <= 1'b0;
        end
    end
endmodule // ipm_far_model
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the idle / power-down mode controller
// assumes ipm_pkg, ipm_ctrl and ipm_far_model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "ipm_cfg.svh"
module tb
    import ipm_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o, r;
    logic global_irq_enable = 1'b0, rfs = 1'b0, nmi_n = 1'b1, lp_run = 1'b0;
    logic [3:0] cprio = 4'h0, fpins = 4'h0, fen = 4'h0, fpol = 4'h0;
    logic [1:0] lp_div = 2'h0;
    logic rtc_irq = 1'b0, ser_irq = 1'b0, rdy_en = 1'b0, rdy_seen = 1'b0;
    ipm_mode_t mode;
    logic halt, pstop, mstop, lpref, isr, trap, round, resume, wdr;
    logic op_valid, prev_done, busy;
    logic [31:0] op_word;
    ipm_req_t wreq;
    int err_total = 0;
    int compares = 0;
    logic [4:0] seen = 5'h0;

    // 100 MHz clock; the slow oscillator stands still when not running
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (lp_run) begin
            lp_div <= lp_div + 2'h1;
        end
    end

    ipm_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .op_valid_i(op_valid), .op_word_i(op_word),
        .prev_done_i(prev_done), .global_irq_enable_i(global_irq_enable), .cpu_prio_i(cprio),
        .return_from_service_i(rfs), .wake_req_i(wreq), .pec_done_i(1'b0),
        .bus_busy_i(busy), .ready_en_i(rdy_en), .ready_seen_i(rdy_seen), .nmi_n_i(nmi_n),
        .fast_external_irq_pins_i(fpins), .fast_irq_en_i(fen),
        .fast_irq_active_high_i(fpol), .lp_osc_clk_i(lp_div[1]), .rtc_irq_i(rtc_irq),
        .serial_irq_i(ser_irq), .mode_o(mode), .cpu_halt_o(halt), .periph_stop_o(pstop),
        .main_osc_stop_o(mstop), .rtc_ref_lp_o(lpref), .isr_enter_o(isr),
        .nmi_trap_o(trap), .prio_round_o(round), .resume_next_o(resume),
        .wdog_reset_o(wdr));
    ipm_far_model far (.clk_i(clk_i), .rst_i(rst_i), .prio_round_i(round),
        .wdog_reset_i(wdr), .op_valid_o(op_valid), .op_word_o(op_word),
        .prev_done_o(prev_done), .wake_req_o(wreq), .bus_busy_o(busy));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string s);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic chk_mode(input ipm_mode_t exp, input string s);
        compares++;
        if (mode !== exp) begin
            err_total++;
            $display("ERROR %0t %s mode %0d exp %0d", $time, s, mode, exp);
        end
    endtask
    // registered outputs read at the edge show the settled value of the cycle before
    task automatic run(input int n);
        seen = 5'h0;
        repeat (n) begin
            @(posedge clk_i);
            seen = seen | {wdr, trap, round, resume, isr};
        end
    endtask
    task automatic wait_mode(input ipm_mode_t m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    // classic single cycle, held until ack is seen at an edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) chk_val(32'h0, 32'h1, "no ack");
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic go(input logic [31:0] op, input ipm_mode_t m);
        far.issue(op);
        wait_mode(m, 8);
    endtask
    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // hang guard, far beyond the roughly five hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        $display("ERROR %0t hang", $time);
        final_report();
    end

    // table of wake cases: pec, ien, kind (0 above cpu, 1 equal, 2 zero), isr, stays idle
    logic [5:0] tab [7] = '{6'b010010, 6'b000000, 6'b010100, 6'b011000,
                            6'b100000, 6'b110100, 6'b110001};
    initial begin
        logic [31:0] w;
        logic [3:0] p, cp;
        void'($urandom(58));
        do_reset();
        chk_mode(IPM_RUN, "rst");
        wb(1'b0, `IPM_REG_CTRL, 4'hf, 32'h0);
        chk_val(r, {29'h0, `IPM_CTRL_RST}, "ctrl");
        wb(1'b0, `IPM_REG_STAT, 4'hf, 32'h0);
        chk_val(r, 32'h1, "stat run");
        wb(1'b0, `IPM_REG_WDOG, 4'hf, 32'h0);
        chk_val({16'h0, r[15:0]}, {16'h0, `IPM_WDOG_RST}, "wdog");
        wb(1'b1, 4'hc, 4'hf, 32'hffffffff);
        wb(1'b0, 4'hc, 4'hf, 32'h0);
        chk_val(r, 32'h0, "unmapped");
        $display("test regs done");
        // refused entries: wrong word, unfinished instruction, busy bus, missed ready
        w = $urandom();
        if (w == `IPM_IDLE_OP || w == `IPM_POWERDOWN_INSTRUCTION_OP) w = w ^ 32'h1;
        far.issue(w);
        run(4);
        chk_mode(IPM_RUN, "bad op");
        for (int k = 0; k < 3; k++) begin
            far.set_bus(k == 1, k != 0);
            rdy_en <= (k == 2);
            go(`IPM_IDLE_OP, IPM_IDLE);
            run(2);
            chk_mode(IPM_RUN, "refused");
        end
        far.set_bus(1'b0, 1'b1);
        rdy_seen <= 1'b1;
        go(`IPM_IDLE_OP, IPM_IDLE);
        chk_mode(IPM_IDLE, "idle");
        chk_val({30'h0, halt, pstop}, 32'h2, "idle halt");
        wb(1'b0, `IPM_REG_STAT, 4'hf, 32'h0);
        chk_val(r, 32'h2, "stat idle");
        rdy_en <= 1'b0;
        do_reset();
        chk_mode(IPM_RUN, "rst exit");
        $display("test entry done");
        for (int i = 0; i < 7; i++) begin
            cp = 4'($urandom_range(13, 0));
            cprio <= cp;
            global_irq_enable <= tab[i][4];
            go(`IPM_IDLE_OP, IPM_IDLE);
            p = tab[i][3:2] == 2'd0 ? cp + 4'd1 + 4'($urandom_range(1, 0)) :
                (tab[i][3:2] == 2'd1 ? cp : 4'h0);
            far.raise(tab[i][5], p);
            run(8);
            chk_val({31'h0, seen[0]}, {31'h0, tab[i][1]}, "isr");
            chk_val({31'h0, seen[2]}, 32'h1, "round");
            if (!tab[i][1]) chk_val({31'h0, seen[1]}, {31'h0, ~tab[i][0]}, "resume");
            chk_mode(tab[i][0] ? IPM_IDLE : IPM_RUN, "wake");
            if (tab[i][1]) begin
                rfs <= 1'b1;
                @(posedge clk_i);
                rfs <= 1'b0;
                run(2);
                chk_val({31'h0, seen[1]}, 32'h1, "return");
            end
        end
        nmi_n <= 1'b0;
        run(8);
        chk_val({30'h0, seen[3:2]}, 32'h3, "nmi");
        chk_mode(IPM_RUN, "nmi exit");
        nmi_n <= 1'b1;
        $display("test wake done");
        w = 32'h40 + 32'($urandom_range(15, 0));
        wb(1'b1, `IPM_REG_WDOG, 4'h3, w);
        go(`IPM_IDLE_OP, IPM_IDLE);
        run(40);
        chk_val({31'h0, seen[4]}, 32'h0, "wdog early");
        run(80);
        chk_val({31'h0, seen[4]}, 32'h1, "wdog");
        chk_mode(IPM_RUN, "wdog exit");
        wb(1'b1, `IPM_REG_WDOG, 4'h3, 32'hffff);
        $display("test wdog done");
        // protected power-down: nmi pin gates entry, only reset leaves
        wb(1'b1, `IPM_REG_CTRL, 4'h1, 32'h0);
        go(`IPM_POWERDOWN_INSTRUCTION_OP, IPM_PDOWN);
        chk_mode(IPM_RUN, "pd nmi high");
        nmi_n <= 1'b0;
        run(4);
        go(`IPM_POWERDOWN_INSTRUCTION_OP, IPM_PDOWN);
        chk_val({30'h0, halt, pstop}, 32'h3, "pd stop");
        fen <= 4'hf;
        fpins <= 4'hf;
        ser_irq <= 1'b1;
        run(10);
        chk_mode(IPM_PDOWN, "pd locked");
        nmi_n <= 1'b1;
        ser_irq <= 1'b0;
        do_reset();
        chk_mode(IPM_RUN, "pd rst");
        // interruptible power-down: pin0 active high, pin2 active low, pin1 disabled
        wb(1'b1, `IPM_REG_CTRL, 4'h1, 32'h3);
        fen <= 4'b0101;
        fpol <= 4'b0001;
        fpins <= 4'b0000;
        run(4);
        go(`IPM_POWERDOWN_INSTRUCTION_OP, IPM_PDOWN);
        chk_mode(IPM_RUN, "pd pin on");
        for (int s = 0; s < 4; s++) begin
            fpins <= 4'b0110;
            lp_run <= (s == 3);
            run(s == 3 ? 40 : 4);
            if (s == 3) chk_val({31'h0, lpref}, 32'h1, "lp");
            go(`IPM_POWERDOWN_INSTRUCTION_OP, IPM_PDOWN);
            chk_mode(IPM_PDOWN, "pd");
            chk_val({31'h0, mstop}, {31'h0, s == 3}, "osc");
            wb(1'b0, `IPM_REG_STAT, 4'hf, 32'h0);
            chk_val(r, s == 3 ? 32'h1c : 32'h4, "stat pd");
            run(4);
            chk_mode(IPM_PDOWN, "pd held");
            fpins <= s == 0 ? 4'b0111 : 4'b0110;
            rtc_irq <= (s == 1);
            ser_irq <= (s >= 2);
            wait_mode(IPM_RUN, 10);
            chk_mode(IPM_RUN, "pd wake");
            rtc_irq <= 1'b0;
            ser_irq <= 1'b0;
        end
        lp_run <= 1'b0;
        run(20);
        chk_val({31'h0, lpref}, 32'h1, "lp kept");
        wb(1'b1, `IPM_REG_CTRL, 4'h1, 32'h7);
        run(6);
        chk_val({31'h0, lpref}, 32'h0, "lp off");
        $display("test pdown done");
        final_report();
    end
endmodule // tb
`default_nettype wire
